// >>> txr_pkg.sv
`default_nettype none
package txr_pkg;
   // Table geometry
   localparam int NUM_CHAN  = 672;
   localparam int NUM_PRI   = 2;
   localparam int NUM_ENT   = NUM_CHAN * NUM_PRI;
   localparam int ROW_W     = 34;
   localparam int PTR_W     = 15;
   localparam int IDX_W     = 11;
   localparam int CHAN_W    = 10;
   // Word 0 of an entry
   localparam int W0_D      = 15;
   localparam int W0_A      = 16;
   localparam int W0_CE     = 17;
   localparam int W0_M      = 18;
   localparam int W0_IOC    = 19;
   localparam int W0_ABRT   = 20;
   localparam int W0_NA     = 21;
   // Word 1: host next pointer low, remaining byte count above
   localparam int W1_CNT_LO = 16;
   localparam int W1_CNT_HI = 31;
   // Word 3
   localparam int W3_V      = 15;
   localparam int W3_LAST_LO = 16;
   localparam int W3_LAST_HI = 30;
   localparam int W3_PIP    = 31;
   localparam int W3_U      = 32;
   // Returned reference lanes / DMA address step
   localparam logic [3:0]  ELEM_LANES = 4'b0111;
   localparam logic [31:0] ADDR_STEP  = 32'h0000_0004;
   // Register byte offsets
   localparam logic [7:0] OFS_CTRL     = 8'h00;
   localparam logic [7:0] OFS_STATUS   = 8'h04;
   localparam logic [7:0] OFS_LAST_REF = 8'h08;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h0C;
   localparam logic [7:0] OFS_IRQ_CLR  = 8'h10;
   localparam logic [7:0] OFS_IRQ_EN   = 8'h14;
   localparam logic [7:0] OFS_TBL_SEL  = 8'h18;
   localparam logic [7:0] OFS_TBL_LO   = 8'h1C;
   localparam logic [7:0] OFS_TBL_HI   = 8'h20;
   localparam logic [7:0] OFS_TBL_CMD  = 8'h24;
   localparam logic [31:0] CTRL_RST    = 32'h0000_0001;
   // Interrupt event bits
   localparam int IRQ_W      = 4;
   localparam int EV_RETURN  = 0;
   localparam int EV_UFLOW   = 1;
   localparam int EV_NOTREAD = 2;
   localparam int EV_SWDONE  = 3;

   typedef enum logic [1:0]
   {
      TXR_LAST_READ = 2'b00,
      TXR_PART_READ = 2'b01,
      TXR_UNPROV    = 2'b10,
      TXR_MALFORMED = 2'b11
   } txr_kind_t;

   typedef struct packed
   {
      logic [CHAN_W-1:0] chan;
      logic              pri;
   } txr_sel_t;

   // Low 24 bits of a free-queue element; lanes above stay untouched
   typedef struct packed
   {
      logic [5:0]       zero_pad;
      logic             uflow;
      txr_kind_t        kind;
      logic [PTR_W-1:0] desc_ref;
   } txr_elem_t;
endpackage : txr_pkg
`default_nettype wire

// >>> txr_return_status.sv
// The AHB-Lite interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module txr_return_status
   import txr_pkg::*;
#(
   parameter int N_CHAN = NUM_CHAN
)
(
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        ce,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic        hready,
   input  wire logic [31:0] hwdata,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   input  wire logic        ret_valid,
   input  wire txr_sel_t    ret_sel,
   input  wire txr_kind_t   ret_kind,
   output logic             ret_ready,
   input  wire logic        uflow_valid,
   input  wire txr_sel_t    uflow_sel,
   output logic             uflow_ready,
   input  wire logic        buf_valid,
   input  wire txr_sel_t    buf_sel,
   input  wire logic [2:0]  buf_bytes,
   output logic             buf_ready,
   output logic             ref_valid,
   output txr_elem_t        ref_elem,
   output logic [3:0]       ref_lanes,
   output logic             irq
);

   typedef enum {SW_IDLE, SW_PEND} txr_sw_t;
   function automatic logic [IDX_W-1:0] ent_idx(input txr_sel_t s);
      ent_idx = IDX_W'({s.chan, s.pri});
   endfunction : ent_idx

   // Table storage, one array per word of an entry
   logic [ROW_W-1:0] tbl_w0 [2*N_CHAN];
   logic [ROW_W-1:0] tbl_w1 [2*N_CHAN];
   logic [ROW_W-1:0] tbl_w2 [2*N_CHAN];
   logic [ROW_W-1:0] tbl_w3 [2*N_CHAN];

   logic [31:0]      ctrl_reg;
   logic [IRQ_W-1:0] irq_stat_reg;
   logic [IRQ_W-1:0] irq_en_reg;
   logic [12:0]      tbl_sel_reg;
   logic [31:0]      tbl_lo_reg;
   logic [1:0]       tbl_hi_reg;
   logic [31:0]      last_ref_reg;
   txr_sw_t          sw_state_reg;
   logic             sw_wr_reg;
   logic             dp_wr_reg;
   logic [7:0]       dp_addr_reg;

   logic             eng_en;
   logic             do_ret;
   logic             do_uf;
   logic             do_buf;
   logic             sw_go;
   logic [IDX_W-1:0] op_idx;
   logic [ROW_W-1:0] r0;
   logic [ROW_W-1:0] r1;
   logic [ROW_W-1:0] r2;
   logic [ROW_W-1:0] r3;
   logic [15:0]      cnt_rd;
   logic [15:0]      cnt_next;
   txr_kind_t        kind_next;
   txr_elem_t        elem_next;
   logic             addr_ph;
   logic             bus_wr;
   logic [IRQ_W-1:0] irq_set;
   logic [IRQ_W-1:0] irq_clr;

   // One engine event per cycle; returns first, so an underflow that meets a
   // return lands one cycle later and survives the flag clear
   assign eng_en      = ctrl_reg[0];
   assign ret_ready   = eng_en;
   assign uflow_ready = eng_en & ~ret_valid;
   assign buf_ready   = eng_en & ~ret_valid & ~uflow_valid;
   assign do_ret      = ce & ret_valid & ret_ready;
   assign do_uf       = ce & uflow_valid & uflow_ready;
   assign do_buf      = ce & buf_valid & buf_ready;
   // Software table access only gets the idle cycles
   assign sw_go       = ce & (sw_state_reg == SW_PEND) & ~do_ret & ~do_uf & ~do_buf;

   assign op_idx = do_ret ? ent_idx(ret_sel) : do_uf ? ent_idx(uflow_sel) :
                   do_buf ? ent_idx(buf_sel) : tbl_sel_reg[12:2];
   assign r0     = tbl_w0[op_idx];
   assign r1     = tbl_w1[op_idx];
   assign r2     = tbl_w2[op_idx];
   assign r3     = tbl_w3[op_idx];
   assign cnt_rd = r1[W1_CNT_HI:W1_CNT_LO];
   // Count stops at zero, which marks the buffer fully read
   assign cnt_next = (cnt_rd > 16'(buf_bytes)) ? cnt_rd - 16'(buf_bytes) : 16'h0000;
   // An inactive entry means the channel was unprovisioned under us
   assign kind_next = r0[W0_A] ? ret_kind : TXR_UNPROV;

   always_comb
   begin
      elem_next          = '0;
      elem_next.uflow    = r3[W3_U];
      elem_next.kind     = kind_next;
      elem_next.desc_ref = r0[PTR_W-1:0];
   end

   // Table writes, field layout per word
   always_ff @(posedge hclk)
   begin
      if (do_ret)
      begin
         tbl_w3[op_idx][W3_U]   <= 1'b0;
         tbl_w3[op_idx][W3_PIP] <= (kind_next == TXR_PART_READ);
      end
      else if (do_uf)
         tbl_w3[op_idx][W3_U] <= 1'b1;
      else if (do_buf)
      begin
         tbl_w1[op_idx][W1_CNT_HI:W1_CNT_LO] <= cnt_next;
         tbl_w2[op_idx][31:0] <= r2[31:0] + ADDR_STEP;
      end
      else if (sw_go && sw_wr_reg)
      begin
         unique case (tbl_sel_reg[1:0])
            2'd0: tbl_w0[op_idx] <= {tbl_hi_reg, tbl_lo_reg};
            2'd1: tbl_w1[op_idx] <= {tbl_hi_reg, tbl_lo_reg};
            2'd2: tbl_w2[op_idx] <= {tbl_hi_reg, tbl_lo_reg};
            2'd3: tbl_w3[op_idx] <= {tbl_hi_reg, tbl_lo_reg};
         endcase
      end
   end

   // Returned reference, written into the low three byte lanes only
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ref_valid    <= 1'b0;
         ref_elem     <= '0;
         ref_lanes    <= 4'h0;
         last_ref_reg <= 32'h0000_0000;
      end
      else if (ce)
      begin
         ref_valid <= do_ret;
         if (do_ret)
         begin
            ref_elem     <= elem_next;
            ref_lanes    <= ELEM_LANES;
            last_ref_reg <= {8'h00, elem_next};
         end
      end
   end

   // AHB-Lite slave: zero wait states, always OKAY
   assign addr_ph   = hsel & htrans[1] & hready;
   assign bus_wr    = ce & dp_wr_reg;
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         dp_wr_reg   <= 1'b0;
         dp_addr_reg <= 8'h00;
         hrdata      <= 32'h0000_0000;
      end
      else if (ce)
      begin
         dp_wr_reg <= addr_ph & hwrite & (haddr[31:8] == 24'h00_0000);
         if (addr_ph)
            dp_addr_reg <= haddr[7:0];
         if (addr_ph && !hwrite && haddr[31:8] == 24'h00_0000)
         begin
            unique case (haddr[7:0])
               OFS_CTRL:     hrdata <= ctrl_reg;
               OFS_STATUS:   hrdata <= {31'h0000_0000, sw_state_reg == SW_PEND};
               OFS_LAST_REF: hrdata <= last_ref_reg;
               OFS_IRQ_STAT: hrdata <= 32'(irq_stat_reg);
               OFS_IRQ_EN:   hrdata <= 32'(irq_en_reg);
               OFS_TBL_SEL:  hrdata <= 32'(tbl_sel_reg);
               OFS_TBL_LO:   hrdata <= tbl_lo_reg;
               OFS_TBL_HI:   hrdata <= 32'(tbl_hi_reg);
               default:      hrdata <= 32'h0000_0000;
            endcase
         end
         else if (addr_ph)
            hrdata <= 32'h0000_0000;
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ctrl_reg    <= CTRL_RST;
         irq_en_reg  <= '0;
         tbl_sel_reg <= 13'h0000;
      end
      else if (bus_wr)
      begin
         if (dp_addr_reg == OFS_CTRL)
            ctrl_reg <= {31'h0000_0000, hwdata[0]};
         if (dp_addr_reg == OFS_IRQ_EN)
            irq_en_reg <= hwdata[IRQ_W-1:0];
         if (dp_addr_reg == OFS_TBL_SEL && sw_state_reg == SW_IDLE)
            tbl_sel_reg <= hwdata[12:0];
      end
   end

   // Data window: a finished table read loads it, else software writes it
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         tbl_lo_reg <= 32'h0000_0000;
         tbl_hi_reg <= 2'b00;
      end
      else if (sw_go && !sw_wr_reg)
      begin
         unique case (tbl_sel_reg[1:0])
            2'd0: {tbl_hi_reg, tbl_lo_reg} <= r0;
            2'd1: {tbl_hi_reg, tbl_lo_reg} <= r1;
            2'd2: {tbl_hi_reg, tbl_lo_reg} <= r2;
            2'd3: {tbl_hi_reg, tbl_lo_reg} <= r3;
         endcase
      end
      else if (bus_wr && sw_state_reg == SW_IDLE)
      begin
         if (dp_addr_reg == OFS_TBL_LO)
            tbl_lo_reg <= hwdata;
         if (dp_addr_reg == OFS_TBL_HI)
            tbl_hi_reg <= hwdata[1:0];
      end
   end

   // Command while pending is dropped; software polls the busy bit
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         sw_state_reg <= SW_IDLE;
         sw_wr_reg    <= 1'b0;
      end
      else if (ce)
      begin
         unique case (sw_state_reg)
            SW_IDLE:
            begin
               if (bus_wr && dp_addr_reg == OFS_TBL_CMD && hwdata[1:0] != 2'b00)
               begin
                  sw_state_reg <= SW_PEND;
                  sw_wr_reg    <= hwdata[1];
               end
            end
            SW_PEND:
            begin
               if (sw_go)
                  sw_state_reg <= SW_IDLE;
            end
         endcase
      end
   end

   // Sticky events; a set in the clearing cycle wins
   always_comb
   begin
      irq_set             = '0;
      irq_set[EV_RETURN]  = do_ret;
      irq_set[EV_UFLOW]   = do_uf;
      irq_set[EV_NOTREAD] = do_ret & kind_next[1];
      irq_set[EV_SWDONE]  = sw_go;
      irq_clr             = (bus_wr && dp_addr_reg == OFS_IRQ_CLR) ? hwdata[IRQ_W-1:0] : '0;
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         irq_stat_reg <= '0;
      else if (ce)
         irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_set;
   end

   assign irq = |(irq_stat_reg & irq_en_reg);

   // Checks
   property p_ref_ptr;
      @(posedge hclk) disable iff (!hresetn)
      do_ret |=> ref_valid && ref_elem.desc_ref == $past(r0[PTR_W-1:0]);
   endproperty
   a_ref_ptr: assert property (p_ref_ptr) else $error("returned offset wrong");
   property p_ref_pad;
      @(posedge hclk) disable iff (!hresetn)
      ref_valid |-> ref_elem.zero_pad == 6'h00 && ref_lanes == 4'b0111;
   endproperty
   a_ref_pad: assert property (p_ref_pad) else $error("element upper bits not protected");
   property p_kind_active;
      @(posedge hclk) disable iff (!hresetn)
      do_ret && r0[W0_A] |=> ref_elem.kind == $past(ret_kind);
   endproperty
   a_kind_active: assert property (p_kind_active) else $error("status code not passed");
   property p_kind_unprov;
      @(posedge hclk) disable iff (!hresetn)
      do_ret && !r0[W0_A] |=> ref_elem.kind == TXR_UNPROV && ref_elem.desc_ref == $past(r0[14:0]);
   endproperty
   a_kind_unprov: assert property (p_kind_unprov) else $error("inactive entry not unprovisioned");
   property p_uflow_bit;
      @(posedge hclk) disable iff (!hresetn)
      do_ret |=> ref_elem.uflow == $past(r3[W3_U]);
   endproperty
   a_uflow_bit: assert property (p_uflow_bit) else $error("underflow bit mismatch");
   property p_uflow_once;
      @(posedge hclk) disable iff (!hresetn)
      do_ret |=> !tbl_w3[$past(op_idx)][W3_U] || $past(do_uf);
   endproperty
   a_uflow_once: assert property (p_uflow_once) else $error("underflow not cleared on return");
   // A stalled underflow must land on its entry in the cycle after the return
   property p_uflow_late;
      @(posedge hclk) disable iff (!hresetn)
      do_ret && uflow_valid ##1 do_uf |=> tbl_w3[$past(op_idx)][W3_U];
   endproperty
   a_uflow_late: assert property (p_uflow_late) else $error("late underflow lost");
   property p_uflow_set;
      @(posedge hclk) disable iff (!hresetn)
      do_uf |=> tbl_w3[$past(op_idx)][W3_U];
   endproperty
   a_uflow_set: assert property (p_uflow_set) else $error("underflow flag not set");
   property p_cnt_dec;
      @(posedge hclk) disable iff (!hresetn)
      do_buf |=> tbl_w1[$past(op_idx)][W1_CNT_HI:W1_CNT_LO] == $past(cnt_next)
                 && $past(cnt_next) <= $past(cnt_rd);
   endproperty
   a_cnt_dec: assert property (p_cnt_dec) else $error("byte count not decremented");
   property p_addr_inc;
      @(posedge hclk) disable iff (!hresetn)
      do_buf |=> tbl_w2[$past(op_idx)][31:0] == $past(r2[31:0]) + 32'h0000_0004;
   endproperty
   a_addr_inc: assert property (p_addr_inc) else $error("DMA address not advanced");

endmodule : txr_return_status
`default_nettype wire

// >>> txr_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module txr_host_model
   import txr_pkg::*;
(
   input  wire logic       hclk,
   input  wire logic       ref_valid,
   input  wire txr_elem_t  ref_elem,
   input  wire logic [3:0] ref_lanes,
   output logic [31:0]     q_last,
   output int              n_unprov,
   output int              n_uflow
);
   logic [31:0] q_mem [8];
   logic [31:0] elem_word;
   logic [2:0]  wr_ptr;

   initial
   begin
      foreach (q_mem[i]) q_mem[i] = 32'hA5FF_FFFF;
      wr_ptr = 3'h0;
      q_last = 32'h0000_0000;
      n_unprov = 0;
      n_uflow = 0;
   end

   // Free-queue memory: only the lanes the block marks are written, the top byte keeps host data
   always @(posedge hclk)
   begin
      if (ref_valid === 1'b1)
      begin
         elem_word = {8'h00, ref_elem};
         for (int l = 0; l < 4; l++)
            if (ref_lanes[l]) q_mem[wr_ptr][8*l +: 8] = elem_word[8*l +: 8];
         q_last = q_mem[wr_ptr];
         wr_ptr = wr_ptr + 3'h1;
         // Unprovisioned return means the host walks the whole chain, counted here only
         if (ref_elem.kind == TXR_UNPROV) n_unprov++;
         // Underflow is kept only as a channel statistic
         if (ref_elem.uflow) n_uflow++;
      end
   end
endmodule : txr_host_model
`default_nettype wire

// >>> tx_descriptor_return_status_bench.sv
`timescale 1ns/100ps
`default_nettype none
module tx_descriptor_return_status_bench
   import txr_pkg::*;
;
   localparam txr_sel_t SA = '{chan: 10'd5, pri: 1'b1};
   localparam txr_sel_t SB = '{chan: 10'd671, pri: 1'b1};
   logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, q_last, v;
   logic [1:0]  htrans;
   logic [2:0]  hsize, buf_bytes;
   logic        ret_valid, ret_ready, uflow_valid, uflow_ready, buf_valid, buf_ready, ref_valid, irq;
   txr_sel_t    ret_sel, uflow_sel, buf_sel;
   txr_kind_t   ret_kind;
   txr_elem_t   ref_elem;
   logic [3:0]  ref_lanes;
   int          n_unprov, n_uflow, num_errors, n_checks;

   assign hready = hreadyout;

   txr_return_status u_dut (.hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .ret_valid(ret_valid), .ret_sel(ret_sel),
      .ret_kind(ret_kind), .ret_ready(ret_ready), .uflow_valid(uflow_valid), .uflow_sel(uflow_sel),
      .uflow_ready(uflow_ready), .buf_valid(buf_valid), .buf_sel(buf_sel), .buf_bytes(buf_bytes),
      .buf_ready(buf_ready), .ref_valid(ref_valid), .ref_elem(ref_elem), .ref_lanes(ref_lanes), .irq(irq));

   txr_host_model u_host (.hclk(hclk), .ref_valid(ref_valid), .ref_elem(ref_elem), .ref_lanes(ref_lanes),
      .q_last(q_last), .n_unprov(n_unprov), .n_uflow(n_uflow));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         num_errors++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : tally_and_finish

   // One single-word transfer; waits on hready, no fixed latency assumed
   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= {24'h00_0000, a};
      hwrite <= wr;
      do @(posedge hclk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      do @(posedge hclk); while (hready !== 1'b1);
      rd = hrdata;
   endtask : ahb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] unused;
      ahb(1'b1, a, d, unused);
   endtask : wr

   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] got;
      ahb(1'b0, a, 32'h0000_0000, got);
      chk(got, exp);
      chk({31'h0, hresp}, 32'h0000_0000);
   endtask : rdc

   // Table access through the window; polls busy until the op lands
   task automatic tbl(input logic [IDX_W-1:0] idx, input logic [1:0] w, input logic [1:0] cmd,
                      input logic [31:0] lo);
      logic [31:0] st;
      wr(OFS_TBL_SEL, {19'h0_0000, idx, w});
      if (cmd[1])
      begin
         wr(OFS_TBL_LO, lo);
         wr(OFS_TBL_HI, 32'h0000_0000);
      end
      wr(OFS_TBL_CMD, {30'h0000_0000, cmd});
      st = 32'h0000_0001;
      while (st[0] !== 1'b0) ahb(1'b0, OFS_STATUS, 32'h0000_0000, st);
   endtask : tbl

   task automatic tblchk(input logic [IDX_W-1:0] idx, input logic [1:0] w, input logic [31:0] exp);
      tbl(idx, w, 2'b01, 32'h0000_0000);
      rdc(OFS_TBL_LO, exp);
   endtask : tblchk

   task automatic ev(input logic is_buf, input txr_sel_t s, input logic [2:0] n);
      @(posedge hclk);
      buf_valid <= is_buf;
      buf_sel <= s;
      buf_bytes <= n;
      uflow_valid <= !is_buf;
      uflow_sel <= s;
      do @(posedge hclk); while ((is_buf ? buf_ready : uflow_ready) !== 1'b1);
      buf_valid <= 1'b0;
      uflow_valid <= 1'b0;
   endtask : ev

   // A return, optionally with an underflow raised in the same cycle for the same entry
   task automatic ret(input txr_sel_t s, input logic [1:0] k, input logic uf, input logic [23:0] exp);
      @(posedge hclk);
      ret_valid <= 1'b1;
      ret_sel <= s;
      ret_kind <= txr_kind_t'(k);
      uflow_valid <= uf;
      uflow_sel <= s;
      do @(posedge hclk); while (ret_ready !== 1'b1);
      ret_valid <= 1'b0;
      #1;
      chk({31'h0, ref_valid}, 32'h0000_0001);
      chk({8'h00, ref_elem}, {8'h00, exp});
      chk({28'h0, ref_lanes}, 32'h0000_0007);
      chk({30'h0, uflow_ready, buf_ready}, {30'h0, 1'b1, ~uf});
      @(posedge hclk);
      uflow_valid <= 1'b0;
      #1;
      chk({31'h0, ref_valid}, 32'h0000_0000);
      chk(q_last, {8'hA5, exp});
   endtask : ret

   task automatic chk_irq(input logic exp);
      #1;
      chk({31'h0, irq}, {31'h0, exp});
   endtask : chk_irq

   initial
   begin
      hclk = 1'b0;
      forever #20 hclk = ~hclk;
   end

   initial
   begin
      repeat (8000) @(posedge hclk);
      num_errors++;
      tally_and_finish();
   end

   initial
   begin
      {hsel, hwrite, ret_valid, uflow_valid, buf_valid} = 5'h00;
      {haddr, hwdata} = 64'h0;
      htrans = 2'b00;
      hsize = 3'b010;
      buf_bytes = 3'h0;
      {ret_sel, uflow_sel, buf_sel} = '0;
      ret_kind = TXR_LAST_READ;
      num_errors = 0;
      n_checks = 0;
      hresetn = 1'b0;
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      rdc(OFS_CTRL, CTRL_RST);
      rdc(OFS_STATUS, 32'h0000_0000);
      rdc(OFS_IRQ_STAT, 32'h0000_0000);
      wr(8'h80, 32'hFFFF_FFFF);
      rdc(8'h80, 32'h0000_0000);
      $display("test registers done");
      tbl(SA, 2'd0, 2'b10, 32'h0001_1234);
      tbl(SA, 2'd1, 2'b10, 32'h0008_0000);
      tbl(SA, 2'd2, 2'b10, 32'h0000_0100);
      tbl(SA, 2'd3, 2'b10, 32'h0000_0000);
      tbl(SB, 2'd0, 2'b10, 32'h0000_0567);
      tbl(SB, 2'd3, 2'b10, 32'h0000_0000);
      tblchk(SA, 2'd0, 32'h0001_1234);
      tblchk(SB, 2'd0, 32'h0000_0567);
      ev(1'b1, SA, 3'd4);
      tblchk(SA, 2'd1, 32'h0004_0000);
      tblchk(SA, 2'd2, 32'h0000_0104);
      ev(1'b1, SA, 3'd7);
      tblchk(SA, 2'd1, 32'h0000_0000);
      tblchk(SA, 2'd2, 32'h0000_0108);
      $display("test table and buffer done");
      ev(1'b0, SA, 3'd0);
      tblchk(SA, 2'd3, 32'h0000_0000);
      rdc(OFS_TBL_HI, 32'h0000_0001);
      ret(SA, 2'b01, 1'b0, 24'h02_9234);
      tblchk(SA, 2'd3, 32'h8000_0000);
      rdc(OFS_TBL_HI, 32'h0000_0000);
      ret(SA, 2'b00, 1'b0, 24'h00_1234);
      ret(SA, 2'b00, 1'b1, 24'h00_1234);
      ret(SA, 2'b00, 1'b0, 24'h02_1234);
      $display("test underflow done");
      for (int k = 0; k < 4; k++)
         ret(SA, k[1:0], 1'b0, {7'h00, k[1:0], 15'h1234});
      $display("test kinds done");
      wr(OFS_IRQ_CLR, 32'h0000_000F);
      rdc(OFS_IRQ_STAT, 32'h0000_0000);
      wr(OFS_IRQ_EN, 32'h0000_0004);
      chk_irq(1'b0);
      ret(SB, 2'b00, 1'b0, 24'h01_0567);
      chk_irq(1'b1);
      rdc(OFS_IRQ_STAT, 32'h0000_0005);
      chk(32'(n_unprov), 32'h0000_0002);
      chk(32'(n_uflow), 32'h0000_0002);
      wr(OFS_IRQ_EN, 32'h0000_0000);
      chk_irq(1'b0);
      wr(OFS_IRQ_CLR, 32'h0000_000F);
      rdc(OFS_IRQ_STAT, 32'h0000_0000);
      $display("test interrupts done");
      wr(OFS_CTRL, 32'h0000_0000);
      #1;
      chk({29'h0, ret_ready, uflow_ready, buf_ready}, 32'h0000_0000);
      wr(OFS_CTRL, CTRL_RST);
      #1;
      chk({29'h0, ret_ready, uflow_ready, buf_ready}, 32'h0000_0007);
      $display("test engine enable done");
      tally_and_finish();
   end
endmodule : tx_descriptor_return_status_bench
`default_nettype wire
